// file: inc/ext_irq_pkg.sv
// package: register map, field positions, reset values and state codes
// for the external interrupt pin logic behind an apb slave port.
// assumes a 32-bit apb bus with byte addresses and one word per register.
package ext_irq_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFS_STATUS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_GLOBAL_MASK    = 8'h04;
    localparam logic [7:0] OFS_EVENT_STATUS   = 8'h08;
    localparam logic [7:0] OFS_EVENT_MASK     = 8'h0c;
    localparam logic [7:0] OFS_PIN_STATE      = 8'h10;

    // ext_int_status_control fields
    localparam int unsigned BIT_MODE    = 0;
    localparam int unsigned BIT_LMASK   = 1;
    localparam int unsigned BIT_ACK     = 2;
    localparam int unsigned BIT_PENDING = 3;

    // global mask register fields
    localparam int unsigned BIT_GMASK = 0;

    // event status / event mask fields
    localparam int unsigned EVT_W         = 4;
    localparam int unsigned EVT_LATCHED   = 0;
    localparam int unsigned EVT_PIN_FALL  = 1;
    localparam int unsigned EVT_VEC_FETCH = 2;
    localparam int unsigned EVT_SW_ACK    = 3;

    // reset values
    localparam logic       RST_MODE       = 1'b0;
    localparam logic       RST_LMASK      = 1'b0;
    localparam logic       RST_GMASK      = 1'b1;
    localparam logic       RST_PIN_IDLE   = 1'b1;
    localparam logic [3:0] RST_EVENT_MASK = 4'h0;

    typedef enum logic [0:0]
    {
        APB_WAIT  = 1'b0,
        APB_READY = 1'b1
    } apb_state_t;

endpackage : ext_irq_pkg

// file: rtl/pin_fall_detect.sv
// falling edge and low level detection on one synchronous active-low pin.
// assumes the pin is already synchronous to pclk.
`timescale 1ns/100ps
module pin_fall_detect
    import ext_irq_pkg::*;
(
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // pin
    input  wire logic pin,
    // detection
    output logic      fall,
    output logic      low,
    output logic      pin_prev
);

    logic prev_reg;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            prev_reg <= RST_PIN_IDLE;
        else
            prev_reg <= pin;
    end

    assign fall     = prev_reg & ~pin;
    assign low      = ~pin;
    assign pin_prev = prev_reg;

endmodule : pin_fall_detect

// file: rtl/sticky_bits.sv
// a vector of sticky flags: hardware sets, clear vector clears.
// a set arriving in the same cycle as its clear wins.
`timescale 1ns/100ps
module sticky_bits #(
    parameter int unsigned WIDTH = 1
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // set and clear
    input  wire logic [WIDTH-1:0] set,
    input  wire logic [WIDTH-1:0] clr,
    // flags
    output logic      [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] flags_reg;
    logic [WIDTH-1:0] flags_next;

    always_comb
    begin
        flags_next = (flags_reg & ~clr) | set;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            flags_reg <= '0;
        else
            flags_reg <= flags_next;
    end

    assign flags = flags_reg;

endmodule : sticky_bits

// file: rtl/ext_irq_pin.sv
// external interrupt pin logic: request latch, local and global masking,
// status/control register and a sticky event interrupt, all behind apb.
// assumes irq_n, vector_fetch and the instruction strobes are synchronous
// to pclk, and that the strobes are one-cycle pulses.
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
module ext_irq_pin
    import ext_irq_pkg::*;
(
    // apb clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    // external pin, active low
    input  wire logic              irq_n,
    // processor side
    input  wire logic              vector_fetch,
    input  wire logic              clear_mask_instruction,
    input  wire logic              set_mask_instruction,
    output logic                   irq_request,
    output logic                   global_mask,
    // event interrupt
    output logic                   event_irq
);

    // state
    apb_state_t       apb_state_reg;
    logic [DATA_W-1:0] prdata_reg;
    logic             pslverr_reg;
    logic             mode_reg;
    logic             lmask_reg;
    logic             gmask_reg;
    logic [EVT_W-1:0] evt_mask_reg;
    logic             irq_request_reg;
    logic             event_irq_reg;

    // combinational
    logic             pin_fall;
    logic             pin_low;
    logic             pin_prev;
    logic             latch_set;
    logic             latch_clr;
    logic             latch_q;
    logic             access;
    logic             wr_done;
    logic             rd_phase;
    logic             addr_ok;
    logic             lane0;
    logic             sw_ack;
    logic [DATA_W-1:0] rd_data;
    logic [EVT_W-1:0] evt_set;
    logic [EVT_W-1:0] evt_clr;
    logic [EVT_W-1:0] evt_flags;

    // pin detection
    pin_fall_detect u_detect
    (
        .clk      (pclk),
        .rst_n    (presetn),
        .pin      (irq_n),
        .fall     (pin_fall),
        .low      (pin_low),
        .pin_prev (pin_prev)
    );

    // apb decode
    assign access  = psel & penable;
    assign wr_done = access & pwrite & (apb_state_reg == APB_READY) & ~pslverr_reg;
    assign rd_phase = access & ~pwrite & (apb_state_reg == APB_WAIT);
    assign lane0   = pstrb[0];

    always_comb
    begin
        addr_ok = 1'b0;
        if (paddr[1:0] == 2'b00)
        begin
            case (paddr)
                OFS_STATUS_CONTROL: addr_ok = 1'b1;
                OFS_GLOBAL_MASK:    addr_ok = 1'b1;
                OFS_EVENT_STATUS:   addr_ok = 1'b1;
                OFS_EVENT_MASK:     addr_ok = 1'b1;
                OFS_PIN_STATE:      addr_ok = 1'b1;
                default:            addr_ok = 1'b0;
            endcase
        end
    end

    // software acknowledge: write 1 to the ack bit
    assign sw_ack = wr_done & lane0 & (paddr == OFS_STATUS_CONTROL)
                    & pwdata[BIT_ACK];

    // request latch: falling edge, or low level in level mode
    assign latch_set = pin_fall
                       | (mode_reg & pin_low);
    assign latch_clr = vector_fetch | sw_ack;

    // set wins over clear, so a level request re-latches while the pin stays low
    sticky_bits #(
        .WIDTH (1)
    ) u_latch
    (
        .clk   (pclk),
        .rst_n (presetn),
        .set   (latch_set),
        .clr   (latch_clr),
        .flags (latch_q)
    );

    // apb handshake: one wait cycle, then pready for one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            apb_state_reg <= APB_WAIT;
        else
        begin
            case (apb_state_reg)
                APB_WAIT:
                    if (access)
                        apb_state_reg <= APB_READY;
                APB_READY:
                    apb_state_reg <= APB_WAIT;
                default:
                    apb_state_reg <= APB_WAIT;
            endcase
        end
    end

    // error answer for unmapped or misaligned addresses
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr_reg <= 1'b0;
        else if (access && apb_state_reg == APB_WAIT)
            pslverr_reg <= ~addr_ok;
        else
            pslverr_reg <= 1'b0;
    end

    // read mux
    always_comb
    begin
        rd_data = '0;
        case (paddr)
            OFS_STATUS_CONTROL:
            begin
                rd_data[BIT_MODE]    = mode_reg;
                rd_data[BIT_LMASK]   = lmask_reg;
                rd_data[BIT_ACK]     = 1'b0;
                rd_data[BIT_PENDING] = latch_q;
            end
            OFS_GLOBAL_MASK:
                rd_data[BIT_GMASK] = gmask_reg;
            OFS_EVENT_STATUS:
                rd_data[EVT_W-1:0] = evt_flags;
            OFS_EVENT_MASK:
                rd_data[EVT_W-1:0] = evt_mask_reg;
            OFS_PIN_STATE:
                rd_data[0] = pin_prev;
            default:
                rd_data = '0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= '0;
        else if (rd_phase && addr_ok)
            prdata_reg <= rd_data;
        else if (rd_phase)
            prdata_reg <= '0;
    end

    // sensitivity select
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_reg <= RST_MODE;
        else if (wr_done && lane0 && paddr == OFS_STATUS_CONTROL)
            mode_reg <= pwdata[BIT_MODE];
    end

    // local request mask; pending flag bit is not writable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lmask_reg <= RST_LMASK;
        else if (wr_done && lane0 && paddr == OFS_STATUS_CONTROL)
            lmask_reg <= pwdata[BIT_LMASK];
    end

    // global interrupt mask of the condition code register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            gmask_reg <= RST_GMASK;
        else if (set_mask_instruction || vector_fetch)
            gmask_reg <= 1'b1;
        else if (clear_mask_instruction)
            gmask_reg <= 1'b0;
    end

    // request to the priority logic
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_request_reg <= 1'b0;
        else
            irq_request_reg <= latch_q & ~latch_clr
                               & ~lmask_reg
                               & ~gmask_reg;
    end

    // event flags, write one to clear
    assign evt_set[EVT_LATCHED]   = latch_set & ~latch_q;
    assign evt_set[EVT_PIN_FALL]  = pin_fall;
    assign evt_set[EVT_VEC_FETCH] = vector_fetch & latch_q;
    assign evt_set[EVT_SW_ACK]    = sw_ack & latch_q;

    assign evt_clr = (wr_done && lane0 && paddr == OFS_EVENT_STATUS) ?
                     pwdata[EVT_W-1:0] : '0;

    sticky_bits #(
        .WIDTH (EVT_W)
    ) u_events
    (
        .clk   (pclk),
        .rst_n (presetn),
        .set   (evt_set),
        .clr   (evt_clr),
        .flags (evt_flags)
    );

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            evt_mask_reg <= RST_EVENT_MASK;
        else if (wr_done && lane0 && paddr == OFS_EVENT_MASK)
            evt_mask_reg <= pwdata[EVT_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            event_irq_reg <= 1'b0;
        else
            event_irq_reg <= |(evt_flags & evt_mask_reg);
    end

    // outputs
    assign prdata      = prdata_reg;
    assign pready      = (apb_state_reg == APB_READY);
    assign pslverr     = pslverr_reg;
    assign irq_request = irq_request_reg;
    assign global_mask = gmask_reg;
    assign event_irq   = event_irq_reg;

endmodule : ext_irq_pin

// file: verification/ext_source.sv
// pin source: an external device pulling the active-low request pin
// assumes the pin has a pull-up, so it idles high while not pulled
`timescale 1ns/100ps
module ext_source
(
    // clock
    input  wire logic pclk,
    // command from the bench
    input  wire logic drive_low,
    // pin
    output logic      irq_n
);
    logic pin_reg = 1'b1;
    always @(posedge pclk)
        pin_reg <= !drive_low;
    assign irq_n = pin_reg;
endmodule : ext_source

// file: verification/ext_irq_properties.sv
// checker: pin request, masking and control register readback
// assumes apb writes land on the edge where pready is sampled high
`timescale 1ns/100ps
module ext_irq_properties
    import ext_irq_pkg::*;
(
    // clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // apb
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic              pready,
    // pin and processor
    input wire logic              irq_n,
    input wire logic              clear_mask_instruction,
    input wire logic              irq_request,
    input wire logic              global_mask
);
    logic [1:0] sh;
    logic       wr0;
    logic       rd0;
    logic       ack_wr;
    assign wr0 = psel && penable && pready && pwrite && paddr == OFS_STATUS_CONTROL && pstrb[0];
    assign rd0 = psel && penable && pready && !pwrite && paddr == OFS_STATUS_CONTROL;
    assign ack_wr = wr0 && pwdata[BIT_ACK];
    // shadow of mode (bit 0) and local mask (bit 1)
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            sh <= 2'h0;
        else if (wr0)
            sh <= pwdata[1:0];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence level_low;
        sh[0] && !sh[1] && !global_mask && !irq_n && !ack_wr;
    endsequence
    a_gmask_reset: assert property ($rose(presetn) |-> global_mask)
        else $error("global mask clear after reset");
    a_gmask_clear: assert property ($fell(global_mask) |-> $past(clear_mask_instruction))
        else $error("global mask cleared without instruction");
    a_lmask_block: assert property (sh[1] && $past(sh[1]) |-> !irq_request)
        else $error("request passed local mask");
    a_gmask_block: assert property (global_mask && $past(global_mask) |-> !irq_request)
        else $error("request passed global mask");
    a_fall_request: assert property ($fell(irq_n) && !global_mask && !sh[1] |-> ##[1:2] irq_request)
        else $error("falling edge gave no request");
    a_ack_clear: assert property (ack_wr && !sh[0] && irq_n |=> ##1 !irq_request)
        else $error("acknowledge left request up");
    a_level_hold: assert property (level_low [*3] |-> irq_request)
        else $error("low level gave no request");
    a_ctrl_read: assert property (rd0 |-> prdata[BIT_ACK] == 1'b0 && prdata[1:0] == sh)
        else $error("control readback wrong");
endmodule : ext_irq_properties
bind ext_irq_pin ext_irq_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .irq_n(irq_n), .irq_request(irq_request),
    .clear_mask_instruction(clear_mask_instruction), .global_mask(global_mask));

// file: verification/test_external_interrupt_pin_logic.sv
// testbench: apb master, processor strobes, pin source and a control model
// assumes one clock and the pin source of ext_source.sv
`timescale 1ns/100ps
module test_external_interrupt_pin_logic
    import ext_irq_pkg::*;
();
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        drive_low = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] seed = 32'h51;
    logic [3:0]  pstrb = 4'hf;
    logic [2:0]  strb = 3'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, irq_n, irq_request, global_mask, event_irq;
    int          fail_count = 0, checks_done = 0, m_mode = 0, m_lmask = 0, m_pend = 0;
    always #2 pclk = ~pclk;
    ext_irq_pin dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq_n(irq_n), .vector_fetch(strb[0]),
        .clear_mask_instruction(strb[1]), .set_mask_instruction(strb[2]),
        .irq_request(irq_request), .global_mask(global_mask), .event_irq(event_irq));
    ext_source u_src (.pclk(pclk), .drive_low(drive_low), .irq_n(irq_n));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic close_out();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic flag(input logic f, input logic e);
        chk({31'h0, f}, {31'h0, e});
    endtask : flag
    task automatic idle();
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask : idle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // pready, read data and error are taken at the completing rising edge
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : apb
    task automatic wrc(input logic [31:0] d);
        apb(1'b1, OFS_STATUS_CONTROL, d);
        m_mode = d[0];
        m_lmask = d[1];
        if (d[2])
            m_pend = 0;
        if (m_mode != 0 && drive_low)
            m_pend = 1;
        idle();
    endtask : wrc
    task automatic rdc();
        apb(1'b0, OFS_STATUS_CONTROL, 32'h0);
        chk(rd, {28'h0, m_pend[0], 1'b0, m_lmask[0], m_mode[0]});
    endtask : rdc
    task automatic pin(input logic v);
        if (v && !drive_low)
            m_pend = 1;
        @(posedge pclk);
        drive_low <= v;
        idle();
    endtask : pin
    task automatic strobe(input logic [2:0] s);
        if (s[0])
            m_pend = 0;
        @(posedge pclk);
        strb <= s;
        @(posedge pclk);
        strb <= 3'h0;
        idle();
    endtask : strobe
    initial
    begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        close_out();
    end
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdc();
        flag(global_mask, 1'b1);
        apb(1'b0, OFS_GLOBAL_MASK, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, OFS_PIN_STATE, 32'h0);
        chk(rd, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            wrc(rnd());
            rdc();
        end
        wrc(32'h0);
        apb(1'b0, 8'h14, 32'h0);
        flag(err, 1'b1);
        strobe(3'h2);
        flag(global_mask, 1'b0);
        apb(1'b0, OFS_GLOBAL_MASK, 32'h0);
        chk(rd, 32'h0);
        pin(1'b1);
        rdc();
        flag(irq_request, 1'b1);
        wrc(32'h2);
        flag(irq_request, 1'b0);
        wrc(32'h0);
        flag(irq_request, 1'b1);
        strobe(3'h4);
        flag(irq_request, 1'b0);
        strobe(3'h2);
        pin(1'b0);
        wrc(32'h4);
        flag(irq_request, 1'b0);
        pin(1'b1);
        strobe(3'h1);
        flag(global_mask, 1'b1);
        rdc();
        strobe(3'h2);
        wrc(32'h1);
        rdc();
        wrc(32'h5);
        rdc();
        pin(1'b0);
        wrc(32'h5);
        rdc();
        wrc(32'h0);
        apb(1'b1, OFS_EVENT_STATUS, 32'hf);
        apb(1'b1, OFS_EVENT_MASK, 32'h1);
        pin(1'b1);
        flag(event_irq, 1'b1);
        apb(1'b0, OFS_EVENT_STATUS, 32'h0);
        chk(rd, 32'h3);
        apb(1'b1, OFS_EVENT_MASK, 32'h0);
        idle();
        flag(event_irq, 1'b0);
        apb(1'b1, OFS_EVENT_MASK, 32'h1);
        apb(1'b1, OFS_EVENT_STATUS, 32'h1);
        idle();
        flag(event_irq, 1'b0);
        apb(1'b0, OFS_EVENT_STATUS, 32'h0);
        chk(rd, 32'h2);
        pin(1'b0);
        rdc();
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        m_pend = 0;
        m_mode = 0;
        m_lmask = 0;
        idle();
        flag(global_mask, 1'b1);
        rdc();
        apb(1'b0, OFS_PIN_STATE, 32'h0);
        chk(rd, 32'h1);
        close_out();
    end
endmodule : test_external_interrupt_pin_logic
